// ==== rtl/wat_core.sv ====
// week alarm timer core with apb register slave
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "wat_defines.svh"
module wat_core #(
  parameter int SLOW_HZ = `WAT_SLOW_HZ,
  parameter int MCLK_HZ = `WAT_MCLK_HZ
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic alarm_o,
  output logic wake_o,
  output logic weekly_wake_o,
  output logic irq_o,
  output wat_pkg::wat_tally_type tally_o
);
  import wat_pkg::*;

  // ==========================================================
  // parameter checks
  // the fractional divider needs at least two main clocks per slow pulse
  if (SLOW_HZ <= 0)
  begin : g_bad_slow
    $error("wat_core: slow rate must be positive");
  end
  if (MCLK_HZ < 2 * SLOW_HZ)
  begin : g_bad_ratio
    $error("wat_core: main clock must be at least twice the slow rate");
  end
  // the accumulator sum must not overflow its 32 bits
  if (MCLK_HZ >= 32'h40000000)
  begin : g_bad_mclk
    $error("wat_core: main clock rate too large for the divider");
  end

  // ==========================================================
  // slow-rate enable: fractional divider keeps 32.768 khz exact on average
  localparam logic [31:0] ACC_STEP = 32'(SLOW_HZ);
  localparam logic [31:0] ACC_MOD = 32'(MCLK_HZ);
  logic [31:0] acc_reg;
  logic slow_en_reg;
  logic [31:0] acc_sum;
  assign acc_sum = acc_reg + ACC_STEP;
  // limitation: each slow pulse may be early or late by one main clock

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      acc_reg <= 32'h00000000;
    else if (acc_sum >= ACC_MOD)
      acc_reg <= acc_sum - ACC_MOD;
    else
      acc_reg <= acc_sum;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      slow_en_reg <= 1'b0;
    else if (acc_sum >= ACC_MOD)
      slow_en_reg <= 1'b1;
    else
      slow_en_reg <= 1'b0;
  end

  // ==========================================================
  // apb decode
  logic acc_ph;
  logic wr_en;
  logic [31:0] ctl_rd;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic run_reg;
  logic gate_reg;
  wat_tally_type tally_reg;
  wat_tally_type thresh_reg;
  wat_presc_type presc_reg;
  wat_tally_type tally_wdata_reg;
  logic tally_wpend_reg;
  assign acc_ph = psel_i & penable_i;
  assign wr_en = acc_ph & pwrite_i;

  // ==========================================================
  // per-register write strobes; a full 12-bit match so aliases never hit
  logic wr_ctl;
  logic wr_tally;
  logic wr_thresh;
  logic wr_status;
  logic wr_mask;
  assign wr_ctl = wr_en & (paddr_i == `WAT_OFF_CONTROL);
  assign wr_tally = wr_en & (paddr_i == `WAT_OFF_TALLY);
  assign wr_thresh = wr_en & (paddr_i == `WAT_OFF_THRESHOLD);
  assign wr_status = wr_en & (paddr_i == `WAT_OFF_IRQ_STATUS);
  assign wr_mask = wr_en & (paddr_i == `WAT_OFF_IRQ_MASK);

  // ==========================================================
  // control and threshold registers
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      run_reg <= `WAT_RST_RUN;
    else if (wr_ctl)
      run_reg <= pwdata_i[`WAT_BIT_RUN];
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      gate_reg <= `WAT_RST_WAKE_GATE;
    else if (wr_ctl)
      gate_reg <= pwdata_i[`WAT_BIT_WAKE_GATE];
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      thresh_reg <= `WAT_RST_THRESHOLD;
    else if (wr_thresh)
      thresh_reg <= pwdata_i[27:0];
  end

  // ==========================================================
  // prescaler and tick
  logic tick;
  assign tick = run_reg & slow_en_reg & (presc_reg == `WAT_PRESCALER_WRAP);
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      presc_reg <= `WAT_RST_PRESCALER;
    else if (!run_reg)
      presc_reg <= `WAT_RST_PRESCALER;
    else if (slow_en_reg)
      presc_reg <= presc_reg + 15'h0001; // wraps 7fff to 0
  end

  // ==========================================================
  // seconds tally; a written value waits for the next slow edge so it
  // lands inside two slow cycles, well within the one second allowed
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      tally_wpend_reg <= 1'b0;
    else if (wr_tally)
      tally_wpend_reg <= 1'b1;
    else if (slow_en_reg)
      tally_wpend_reg <= 1'b0;
  end

  // the last write before the slow edge wins
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      tally_wdata_reg <= `WAT_RST_TALLY;
    else if (wr_tally)
      tally_wdata_reg <= pwdata_i[27:0];
  end

  // a tick that meets a pending load is dropped: the written value rules

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      tally_reg <= `WAT_RST_TALLY;
    else if (slow_en_reg && tally_wpend_reg)
      tally_reg <= tally_wdata_reg;
    else if (tick)
      tally_reg <= tally_reg + 28'h0000001;
  end

  // ==========================================================
  // alarm, wake and interrupt
  logic reached;
  assign reached = run_reg & (tally_reg >= thresh_reg);
  // registered outputs, one flop per pin so none glitches toward the rail
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      alarm_o <= 1'b0;
    else
      alarm_o <= reached;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      wake_o <= 1'b0;
    else
      wake_o <= reached & gate_reg;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      weekly_wake_o <= 1'b0;
    else
      weekly_wake_o <= reached & gate_reg;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      tally_o <= `WAT_RST_TALLY;
    else
      tally_o <= tally_reg;
  end

  logic [2:0] irq_ev;
  always_comb
  begin
    irq_ev = 3'h0;
    irq_ev[`WAT_IRQ_ALARM] = reached;
    irq_ev[`WAT_IRQ_WAKE] = reached & gate_reg;
    irq_ev[`WAT_IRQ_TICK] = tick;
  end

  // ==========================================================
  // interrupt status and mask
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_status_reg <= 3'h0;
    else if (wr_status)
      irq_status_reg <= (irq_status_reg & ~pwdata_i[2:0]) | irq_ev;
    else
      irq_status_reg <= irq_status_reg | irq_ev;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_mask_reg <= 3'h0;
    else if (wr_mask)
      irq_mask_reg <= pwdata_i[2:0];
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_status_reg & irq_mask_reg);
  end

  // ==========================================================
  // read path: no wait state, data registered with pready
  always_comb
  begin
    ctl_rd = 32'h00000000;
    ctl_rd[`WAT_BIT_RUN] = run_reg;
    ctl_rd[`WAT_BIT_WAKE_GATE] = gate_reg;
  end

  // ==========================================================
  // read mux; registers outside this block read zero, writes ignored
  logic [31:0] rd_next;
  logic known;
  always_comb
  begin
    rd_next = 32'h00000000;
    known = 1'b1;
    case (paddr_i)
      `WAT_OFF_CONTROL:
      begin
        rd_next = ctl_rd;
      end
      `WAT_OFF_TALLY:
      begin
        rd_next = {4'h0, tally_reg};
      end
      `WAT_OFF_THRESHOLD:
      begin
        rd_next = {4'h0, thresh_reg};
      end
      `WAT_OFF_PRESCALER:
      begin
        rd_next = {17'h00000, presc_reg};
      end
      `WAT_OFF_RATE_SEL:
      begin
        rd_next = 32'h00000000;
      end
      `WAT_OFF_SHORT_CTL:
      begin
        rd_next = 32'h00000000;
      end
      `WAT_OFF_SHORT_CNT:
      begin
        rd_next = 32'h00000000;
      end
      `WAT_OFF_HELD_LVL:
      begin
        rd_next = 32'h00000000;
      end
      `WAT_OFF_HELD_SEL:
      begin
        rd_next = 32'h00000000;
      end
      `WAT_OFF_HELD_RST:
      begin
        rd_next = 32'h00000000;
      end
      `WAT_OFF_IRQ_STATUS:
      begin
        rd_next = {29'h00000000, irq_status_reg};
      end
      `WAT_OFF_IRQ_MASK:
      begin
        rd_next = {29'h00000000, irq_mask_reg};
      end
      default:
      begin
        known = 1'b0;
      end
    endcase
  end

  // the answer is built in setup, so the access phase has no wait state
  logic setup_ph;
  assign setup_ph = psel_i & ~penable_i;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      pready_o <= 1'b0;
    else if (setup_ph)
      pready_o <= 1'b1;
    else
      pready_o <= 1'b0;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      pslverr_o <= 1'b0;
    else if (setup_ph)
      pslverr_o <= ~known;
    else
      pslverr_o <= 1'b0;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      prdata_o <= 32'h00000000;
    else if (setup_ph)
      prdata_o <= pwrite_i ? 32'h00000000 : rd_next;
    else
      prdata_o <= 32'h00000000;
  end
endmodule : wat_core

// ==== rtl/wat_defines.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef WAT_DEFINES_SVH
`define WAT_DEFINES_SVH
`define WAT_OFF_CONTROL 12'h000
`define WAT_OFF_TALLY 12'h004
`define WAT_OFF_THRESHOLD 12'h008
`define WAT_OFF_PRESCALER 12'h00c
`define WAT_OFF_RATE_SEL 12'h010
`define WAT_OFF_SHORT_CTL 12'h014
`define WAT_OFF_SHORT_CNT 12'h018
`define WAT_OFF_HELD_LVL 12'h01c
`define WAT_OFF_HELD_SEL 12'h020
`define WAT_OFF_HELD_RST 12'h024
`define WAT_OFF_IRQ_STATUS 12'h028
`define WAT_OFF_IRQ_MASK 12'h02c
`define WAT_BIT_RUN 0
`define WAT_BIT_WAKE_GATE 6
`define WAT_RST_RUN 1'b1
`define WAT_RST_WAKE_GATE 1'b0
`define WAT_RST_TALLY 28'h0000000
`define WAT_RST_THRESHOLD 28'h0ffffff
`define WAT_RST_PRESCALER 15'h0000
`define WAT_PRESCALER_WRAP 15'h7fff
`define WAT_MCLK_HZ 20000000
`define WAT_SLOW_HZ 32768
`define WAT_IRQ_ALARM 0
`define WAT_IRQ_WAKE 1
`define WAT_IRQ_TICK 2
`endif

// ==== rtl/wat_pkg.sv ====
// shared types of the week alarm timer core
package wat_pkg;
  typedef logic [27:0] wat_tally_type;
  typedef logic [14:0] wat_presc_type;
  typedef logic [2:0] wat_irq_type;
endpackage : wat_pkg

// ==== test/wat_core_properties.sv ====
// concurrent checks on the timer core ports
`timescale 1ns/1ps
module wat_core_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic alarm_o,
  input wire logic wake_o,
  input wire logic weekly_wake_o,
  input wire wat_pkg::wat_tally_type tally_o
);
  import wat_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================
  // bus answer
  a_ready_after_setup: assert property (
    psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_one_pulse: assert property (
    pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (
    pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error without ready or with data");
  a_idle_data_zero: assert property (
    !pready_o |-> prdata_o == 32'h0)
    else $error("read data outside access");
  // ==========================================================
  // counting and alarm
  a_tally_step_one: assert property (
    (!psel_i)[*5] ##1 $changed(tally_o)
    |-> tally_o == $past(tally_o) + 28'h1)
    else $error("tally moved by other than one");
  a_alarm_stays_up: assert property (
    (!psel_i)[*4] |=> !$fell(alarm_o))
    else $error("alarm dropped with no access");
  a_wake_needs_alarm: assert property (
    $rose(wake_o) |-> alarm_o)
    else $error("wake without alarm");
  a_weekly_follows: assert property (
    weekly_wake_o == wake_o)
    else $error("weekly wake differs from wake");
endmodule : wat_core_checker

// ==== test/tb_wat_core.sv ====
// self-checking bench for the timer core
`timescale 1ns/1ps
module tb_wat_core;
  import wat_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, alarm_o, wake_o, weekly_wake_o, irq_o;
  wat_tally_type tally_o;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  always #25 mclk_i = ~mclk_i;
  // fast slow-enable every other clock so one second is 65536 cycles
  wat_core #(.SLOW_HZ(10000000), .MCLK_HZ(20000000)) u_wat_core (.mclk_i,
    .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .alarm_o, .wake_o, .weekly_wake_o, .irq_o,
    .tally_o);
  task print_verdict;
    $display("mismatches %0d of %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one apb transfer; read answer kept in the last two arguments
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic er);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    @(posedge mclk_i);
    while (pready_o !== 1'b1 && n < 20)
    begin
      @(posedge mclk_i);
      n++;
    end
    if (n == 20)
    begin
      n_mismatch++;
      print_verdict();
    end
    r = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("rdata", r, x);
    chk("slverr", {31'h0, e}, {31'h0, xe});
  endtask : rd
  task s_reset_regs;
    rd(12'h000, 32'h1, 1'b0);
    rd(12'h004, 32'h0, 1'b0);
    rd(12'h008, 32'h0ffffff, 1'b0);
    rd(12'h030, 32'h0, 1'b1);
    wr(12'h000, 32'hffffffff);
    rd(12'h000, 32'h41, 1'b0);
    wr(12'h000, 32'h1);
  endtask : s_reset_regs
  task s_alarm_wake;
    wr(12'h008, 32'h5);
    repeat (4) @(posedge mclk_i);
    chk("alarm", alarm_o, 1'b0);
    wr(12'h004, 32'h5);
    repeat (4) @(posedge mclk_i);
    chk("alarm", alarm_o, 1'b1);
    chk("wake", wake_o, 1'b0);
    wr(12'h000, 32'h41);
    wr(12'h02c, 32'h1);
    repeat (3) @(posedge mclk_i);
    chk("wake", wake_o, 1'b1);
    chk("weekly", weekly_wake_o, 1'b1);
    chk("irq", irq_o, 1'b1);
    wr(12'h02c, 32'h0);
    repeat (3) @(posedge mclk_i);
    chk("irq", irq_o, 1'b0);
    wr(12'h008, 32'h0ffffff);
    wr(12'h028, 32'h7);
    wr(12'h02c, 32'h7);
    repeat (3) @(posedge mclk_i);
    chk("irq", irq_o, 1'b0);
  endtask : s_alarm_wake
  task s_stop_resume;
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h64);
    repeat (4) @(posedge mclk_i);
    rd(12'h004, 32'h64, 1'b0);
    rd(12'h00c, 32'h0, 1'b0);
    wr(12'h008, 32'h65);
    wr(12'h000, 32'h1);
    chk("alarm", alarm_o, 1'b0);
    for (int i = 0; i < 70000 && tally_o !== 28'h65; i++)
      @(posedge mclk_i);
    chk("tally", {4'h0, tally_o}, 32'h65);
    repeat (3) @(posedge mclk_i);
    chk("alarm", alarm_o, 1'b1);
    wr(12'h02c, 32'h4);
    repeat (3) @(posedge mclk_i);
    chk("irq", irq_o, 1'b1);
  endtask : s_stop_resume
  initial
  begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    s_reset_regs();
    s_alarm_wake();
    s_stop_resume();
    print_verdict();
  end
endmodule : tb_wat_core
bind wat_core wat_core_checker u_wat_core_checker (.mclk_i, .rst_i,
  .psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o, .alarm_o, .wake_o,
  .weekly_wake_o, .tally_o);
